//--- pco_defines.svh
// Constants for the clock synthesizer and clock output configuration block.
// Assumes inclusion by pco_pkg.sv and the design modules by bare name.
`ifndef PCO_DEFINES_SVH
`define PCO_DEFINES_SVH

// Register offsets on the serial control port
`define PCO_ADDR_REFO      8'h3c
`define PCO_ADDR_FBDIV12   8'h3d
`define PCO_ADDR_FBDIV3    8'h3e
`define PCO_ADDR_OSC       8'h3f
`define PCO_ADDR_PE        8'h48
`define PCO_ADDR_TRIG      8'h57

// Reset values
`define PCO_RST_REFO       8'h01
`define PCO_RST_FBDIV12    8'h00
`define PCO_RST_FBDIV3     8'h20
`define PCO_RST_OSC        8'h4f
`define PCO_RST_PE         8'h00
`define PCO_RST_TRIG       8'h00
`define PCO_RST_RDATA      8'h00

// Field positions
`define PCO_REFO_EN_BIT    0
`define PCO_SECOND_MSB     3
`define PCO_SECOND_LSB     2
`define PCO_FIRST_MSB      1
`define PCO_FIRST_LSB      0
`define PCO_THIRD_MSB      5
`define PCO_OSC_MSB        6
`define PCO_PE_MSB         3
`define PCO_TRIG_EN_BIT    7
`define PCO_TRIG_MODE_MSB  2

// Encodings
`define PCO_DIV_RESERVED   2'h3
`define PCO_THIRD_ILLEGAL  6'h00
`define PCO_MODE_UI16      3'h0
`define PCO_MODE_UI32      3'h1
`define PCO_MODE_UI64      3'h2
`define PCO_MODE_TSTAMP    3'h3
`define PCO_LANES          8

// Last tick index of each half period of the trigger clock
`define PCO_HALF_UI16      6'h07
`define PCO_HALF_UI32      6'h0f
`define PCO_HALF_UI64      6'h1f

`endif

//--- pco_pkg.sv
// Types for the clock synthesizer and clock output configuration block.
// Assumes pco_defines.svh is on the include path.
`default_nettype none
`include "pco_defines.svh"

package pco_pkg;

	// Software-visible register images
	typedef struct packed {
		logic [7:0] refo;
		logic [7:0] fbdiv12;
		logic [7:0] fbdiv3;
		logic [7:0] osc;
		logic [7:0] pe;
		logic [7:0] trig;
	} pco_regs_t;

	// Divider settings as handed to the synthesizer
	typedef struct packed {
		logic [1:0] first_code;
		logic [1:0] second_code;
		logic [5:0] third_ratio;
	} pco_div_cfg_t;

	// Whole state of the configuration module
	typedef struct packed {
		pco_regs_t    regs;
		pco_div_cfg_t applied;
		logic [7:0]   rdata;
		logic         rvalid;
		logic [1:0]   en_sync;
		logic [1:0]   rst_sync;
		logic         ref_out;
	} pco_state_t;

	// Whole state of the trigger output divider
	typedef struct packed {
		logic [5:0] cnt;
		logic       pin;
		logic [1:0] ts_sync;
	} pco_trig_state_t;

endpackage : pco_pkg

`default_nettype wire

//--- pco_trig_div.sv
// Trigger output divider: UI clock divider or resampled timestamp.
// Assumes i_ui_tick and i_serdes_reinit come from the same clock domain;
// the timestamp input is an asynchronous pin.
`default_nettype none
`include "pco_defines.svh"

module pco_trig_div
	import pco_pkg::*;
(
	input  wire logic       i_clock,
	input  wire logic       i_resetn,
	input  wire logic       i_enable,
	input  wire logic [2:0] i_mode,
	input  wire logic       i_ui_tick,
	input  wire logic       i_serdes_reinit,
	input  wire logic       i_timestamp_input,
	output var  logic       o_trig_output_pin
);

	pco_trig_state_t st_r;   // Registered state
	pco_trig_state_t st_nxt; // Next state
	logic [5:0]      half;   // Last tick of a half period

	// Next-state logic
	always_comb begin
		half = `PCO_HALF_UI16;
		st_nxt = st_r;
		st_nxt.ts_sync = {st_r.ts_sync[0], i_timestamp_input};
		case (i_mode)
			`PCO_MODE_UI32: half = `PCO_HALF_UI32;
			`PCO_MODE_UI64: half = `PCO_HALF_UI64;
			default:        half = `PCO_HALF_UI16;
		endcase
		if (!i_enable) begin
			st_nxt.cnt = 6'h00;
			st_nxt.pin = 1'b0;
		end else if (i_mode == `PCO_MODE_TSTAMP) begin
			st_nxt.cnt = 6'h00;
			st_nxt.pin = st_r.ts_sync[1];
		end else if (i_mode <= `PCO_MODE_UI64) begin
			if (i_serdes_reinit) begin
				// Output drops while the serializer re-initialises
				st_nxt.cnt = 6'h00;
				st_nxt.pin = 1'b0;
			end else if (i_ui_tick) begin
				if (st_r.cnt >= half) begin
					st_nxt.cnt = 6'h00;
					st_nxt.pin = ~st_r.pin;
				end else begin
					st_nxt.cnt = st_r.cnt + 6'h01;
				end
			end
		end else begin
			// Reserved modes keep the pin quiet rather than guess
			st_nxt.cnt = 6'h00;
			st_nxt.pin = 1'b0;
		end
	end

	// State register
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_trig_output_pin = st_r.pin;

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_resetn);

	a_trig_off_quiet: assert property (!i_enable |=> !o_trig_output_pin)
		else $error("trigger pin active while disabled");
	a_trig_tstamp: assert property (
		(i_enable && i_mode == `PCO_MODE_TSTAMP) |=> o_trig_output_pin == $past(st_r.ts_sync[1]))
		else $error("timestamp copy wrong");
	a_trig_reinit: assert property (
		(i_enable && i_mode <= `PCO_MODE_UI64 && i_serdes_reinit) |=> !o_trig_output_pin)
		else $error("trigger clock not interrupted on reinit");
	c_trig_toggle: cover property (i_enable && i_mode == `PCO_MODE_UI16 ##1 $rose(o_trig_output_pin));

endmodule // pco_trig_div

`default_nettype wire

//--- pco_top.sv
// Clock synthesizer and clock output configuration registers.
// Assumes register port signals are synchronous to i_clock; the synthesizer
// enable pin, synthesizer reset control and timestamp are asynchronous.
//
// Operation
// - Reference output follows enable bit and pin
// - Reference output enable resets to one
// - Second divider codes 1,2,4; reset zero
// - First divider codes 5,4,3; reset zero
// - Third divider ratio 1 to 63, reset 32
// - One pre-emphasis setting for all lanes
// - Trigger enable gates trigger buffer and divider
// - Trigger modes 16/32/64 UI, timestamp copy
// - Serializer reinit briefly interrupts trigger clock
`default_nettype none
`include "pco_defines.svh"

module pco_top
	import pco_pkg::*;
(
	input  wire logic       i_clock,
	input  wire logic       i_resetn,
	input  wire logic       i_reg_wr,
	input  wire logic       i_reg_rd,
	input  wire logic [7:0] i_reg_addr,
	input  wire logic [7:0] i_reg_wdata,
	input  wire logic       i_synth_enable,
	input  wire logic       i_synth_reset_ctrl,
	input  wire logic       i_ui_tick,
	input  wire logic       i_serdes_reinit,
	input  wire logic       i_timestamp_input,
	output var  logic [7:0] o_reg_rdata,
	output var  logic       o_reg_rvalid,
	output var  logic       o_ref_clock_out,
	output var  pco_div_cfg_t o_div_cfg,
	output var  logic [6:0] o_oscillator_bias,
	output var  logic [`PCO_LANES-1:0][3:0] o_lane_preemphasis,
	output var  logic       o_trig_output_enable,
	output var  logic       o_trig_output_pin
);

	pco_state_t st_r;   // Registered state
	pco_state_t st_nxt; // Next state

	// Register writes, read answer, synchronisers and applied dividers
	always_comb begin
		st_nxt = st_r;
		// Only the second stage of each synchroniser is read below
		st_nxt.en_sync = {st_r.en_sync[0], i_synth_enable};
		st_nxt.rst_sync = {st_r.rst_sync[0], i_synth_reset_ctrl};
		st_nxt.rvalid = i_reg_rd;
		// Writes store the whole byte; reserved bits are the host's duty
		if (i_reg_wr) begin
			if (i_reg_addr == `PCO_ADDR_REFO) begin
				st_nxt.regs.refo = i_reg_wdata;
			end else if (i_reg_addr == `PCO_ADDR_FBDIV12) begin
				st_nxt.regs.fbdiv12 = i_reg_wdata;
			end else if (i_reg_addr == `PCO_ADDR_FBDIV3) begin
				st_nxt.regs.fbdiv3 = i_reg_wdata;
			end else if (i_reg_addr == `PCO_ADDR_OSC) begin
				st_nxt.regs.osc = i_reg_wdata;
			end else if (i_reg_addr == `PCO_ADDR_PE) begin
				st_nxt.regs.pe = i_reg_wdata;
			end else if (i_reg_addr == `PCO_ADDR_TRIG) begin
				st_nxt.regs.trig = i_reg_wdata;
			end
		end
		// Read answer, registered; unmapped offsets read zero
		if (i_reg_rd) begin
			if (i_reg_addr == `PCO_ADDR_REFO) begin
				st_nxt.rdata = st_r.regs.refo;
			end else if (i_reg_addr == `PCO_ADDR_FBDIV12) begin
				st_nxt.rdata = st_r.regs.fbdiv12;
			end else if (i_reg_addr == `PCO_ADDR_FBDIV3) begin
				st_nxt.rdata = st_r.regs.fbdiv3;
			end else if (i_reg_addr == `PCO_ADDR_OSC) begin
				st_nxt.rdata = st_r.regs.osc;
			end else if (i_reg_addr == `PCO_ADDR_PE) begin
				st_nxt.rdata = st_r.regs.pe;
			end else if (i_reg_addr == `PCO_ADDR_TRIG) begin
				st_nxt.rdata = st_r.regs.trig;
			end else begin
				st_nxt.rdata = `PCO_RST_RDATA;
			end
		end
		st_nxt.ref_out = st_r.regs.refo[`PCO_REFO_EN_BIT] & st_r.en_sync[1];
		// Holding the old ratios keeps the loop steady while the host rewrites them
		// Apply only outside reset
		if (!st_r.rst_sync[1]) begin
			// A reserved code would leave the loop at an undefined ratio, so it is dropped
			// First divider code
			if (st_r.regs.fbdiv12[`PCO_FIRST_MSB:`PCO_FIRST_LSB] != `PCO_DIV_RESERVED) begin
				st_nxt.applied.first_code = st_r.regs.fbdiv12[`PCO_FIRST_MSB:`PCO_FIRST_LSB];
			end
			if (st_r.regs.fbdiv12[`PCO_SECOND_MSB:`PCO_SECOND_LSB] != `PCO_DIV_RESERVED) begin
				st_nxt.applied.second_code =
					st_r.regs.fbdiv12[`PCO_SECOND_MSB:`PCO_SECOND_LSB];
			end
			// Third ratio; zero is unsupported and ignored
			if (st_r.regs.fbdiv3[`PCO_THIRD_MSB:0] != `PCO_THIRD_ILLEGAL) begin
				st_nxt.applied.third_ratio = st_r.regs.fbdiv3[`PCO_THIRD_MSB:0];
			end
		end
	end

	// State register; reset values make the reference output come up alone
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			st_r.regs.refo <= `PCO_RST_REFO;
			st_r.regs.fbdiv12 <= `PCO_RST_FBDIV12;
			st_r.regs.fbdiv3 <= `PCO_RST_FBDIV3;
			st_r.regs.osc <= `PCO_RST_OSC;
			st_r.regs.pe <= `PCO_RST_PE;
			st_r.regs.trig <= `PCO_RST_TRIG;
			// Applied dividers start at the reset ratios of their fields
			st_r.applied.first_code <= 2'h0;
			st_r.applied.second_code <= 2'h0;
			st_r.applied.third_ratio <= 6'h20;
			// Read port idle
			st_r.rdata <= `PCO_RST_RDATA;
			st_r.rvalid <= 1'b0;
			// Synchronisers start low, so the reference output waits for the pin
			st_r.en_sync <= 2'h0;
			st_r.rst_sync <= 2'h0;
			st_r.ref_out <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	generate
		for (genvar g = 0; g < `PCO_LANES; g++) begin : g_lane
			assign o_lane_preemphasis[g] = st_r.regs.pe[`PCO_PE_MSB:0];
		end
	endgenerate

	// Outputs straight from state flops
	assign o_reg_rdata = st_r.rdata;
	assign o_reg_rvalid = st_r.rvalid;
	assign o_ref_clock_out = st_r.ref_out;
	assign o_div_cfg = st_r.applied;
	// Bias passes through as written; choosing 0x4A is the host's job
	assign o_oscillator_bias = st_r.regs.osc[`PCO_OSC_MSB:0];
	assign o_trig_output_enable = st_r.regs.trig[`PCO_TRIG_EN_BIT];

	// Trigger output divider; mode changes while enabled are not guarded
	pco_trig_div u_trig (
		.i_clock          (i_clock),
		.i_resetn         (i_resetn),
		.i_enable         (st_r.regs.trig[`PCO_TRIG_EN_BIT]),
		.i_mode           (st_r.regs.trig[`PCO_TRIG_MODE_MSB:0]),
		.i_ui_tick        (i_ui_tick),
		.i_serdes_reinit  (i_serdes_reinit),
		.i_timestamp_input(i_timestamp_input),
		.o_trig_output_pin(o_trig_output_pin)
	);

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_resetn);

	// Reference output checks
	a_ref_out_on: assert property (
		(st_r.regs.refo[0] && st_r.en_sync[1]) |=> o_ref_clock_out)
		else $error("reference output not driven");
	a_ref_out_off: assert property (
		(!st_r.regs.refo[0] || !st_r.en_sync[1]) |=> !o_ref_clock_out)
		else $error("reference output driven while gated");
	a_ref_reset_on: assert property ($rose(i_resetn) |-> st_r.regs.refo[0])
		else $error("reference enable not set after reset");
	// Divider checks; a reserved code must leave the applied ratio alone
	a_second_apply: assert property (
		(!st_r.rst_sync[1] && st_r.regs.fbdiv12[3:2] != 2'h3)
		|=> o_div_cfg.second_code == $past(st_r.regs.fbdiv12[3:2]))
		else $error("second divider not applied");
	a_second_hold: assert property (
		st_r.regs.fbdiv12[3:2] == 2'h3 |=> $stable(o_div_cfg.second_code))
		else $error("reserved second divider code applied");
	a_first_apply: assert property (
		(!st_r.rst_sync[1] && st_r.regs.fbdiv12[1:0] != 2'h3)
		|=> o_div_cfg.first_code == $past(st_r.regs.fbdiv12[1:0]))
		else $error("first divider not applied");
	a_first_hold: assert property (
		st_r.regs.fbdiv12[1:0] == 2'h3 |=> $stable(o_div_cfg.first_code))
		else $error("reserved first divider code applied");
	a_third_apply: assert property (
		(!st_r.rst_sync[1] && st_r.regs.fbdiv3[5:0] != 6'h00)
		|=> o_div_cfg.third_ratio == $past(st_r.regs.fbdiv3[5:0]))
		else $error("third divider not applied");
	a_third_legal: assert property (o_div_cfg.third_ratio != 6'h00)
		else $error("third divider ratio zero");
	a_div_hold: assert property (st_r.rst_sync[1] |=> $stable(o_div_cfg))
		else $error("dividers changed during synth reset");
	// Lane and trigger checks
	a_lanes_common: assert property (
		o_lane_preemphasis == {`PCO_LANES{o_lane_preemphasis[0]}})
		else $error("lanes differ in pre-emphasis");
	a_lanes_write: assert property (
		(i_reg_wr && i_reg_addr == `PCO_ADDR_PE)
		|=> o_lane_preemphasis[`PCO_LANES-1] == $past(i_reg_wdata[3:0]))
		else $error("pre-emphasis write not applied");
	a_trig_gate: assert property (!o_trig_output_enable [*2] |-> !o_trig_output_pin)
		else $error("trigger pin active while disabled");
	// Register port checks
	a_read_answer: assert property (i_reg_rd |=> o_reg_rvalid)
		else $error("read not answered");
	a_read_idle: assert property (!i_reg_rd |=> !o_reg_rvalid)
		else $error("read answer without a read");
	a_read_data: assert property ((i_reg_rd && i_reg_addr == `PCO_ADDR_TRIG)
		|=> o_reg_rdata == $past(st_r.regs.trig))
		else $error("trigger control read back wrong");
	a_bias_write: assert property ((i_reg_wr && i_reg_addr == `PCO_ADDR_OSC)
		|=> o_oscillator_bias == $past(i_reg_wdata[6:0]))
		else $error("oscillator bias write not applied");
	// Scenario covers
	c_div_change: cover property (st_r.rst_sync[1] ##1 !st_r.rst_sync[1] ##1 $changed(o_div_cfg));
	c_ref_on: cover property ($rose(o_ref_clock_out));
	c_trig_on: cover property ($rose(o_trig_output_enable) ##[1:40] o_trig_output_pin);
	c_reserved_code: cover property (!st_r.rst_sync[1] && st_r.regs.fbdiv12[1:0] == 2'h3);

endmodule // pco_top

`default_nettype wire

//--- pco_host_model.sv
// Host model for the configuration block: register port and synth reset.
// Assumes the bench clock; every change lands on a falling edge.
`default_nettype none

module pco_host_model (
	input  wire logic       i_clock,
	input  wire logic [7:0] i_reg_rdata,
	input  wire logic       i_reg_rvalid,
	output var  logic       o_reg_wr,
	output var  logic       o_reg_rd,
	output var  logic [7:0] o_reg_addr,
	output var  logic [7:0] o_reg_wdata,
	output var  logic       o_synth_reset_ctrl
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle port at time zero
	initial begin
		o_reg_wr = 1'b0;
		o_reg_rd = 1'b0;
		o_reg_addr = 8'h00;
		o_reg_wdata = 8'h00;
		o_synth_reset_ctrl = 1'b0;
	end

	function automatic logic [7:0] keep(input logic [7:0] a);
		case (a)
			8'h3c: keep = 8'h01;
			8'h3d: keep = 8'h0f;
			8'h3e: keep = 8'h3f;
			8'h3f: keep = 8'h7f;
			8'h48: keep = 8'h0f;
			8'h57: keep = 8'h87;
			default: keep = 8'hff;
		endcase
	endfunction

	// One strobe cycle; the answer stands for one cycle after the taking edge,
	// so it is sampled at the next falling edge, before the lines are released.
	// Released address and data lines are inverted so stale values never match
	task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q, output logic v);
		@(negedge i_clock);
		o_reg_wr <= w;
		o_reg_rd <= ~w;
		o_reg_addr <= a;
		o_reg_wdata <= d;
		@(negedge i_clock);
		v = i_reg_rvalid;
		q = i_reg_rdata;
		o_reg_wr <= 1'b0;
		o_reg_rd <= 1'b0;
		o_reg_addr <= ~a;
		o_reg_wdata <= ~d;
	endtask

	task automatic write(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q; // Unused answer
		logic       v; // Unused answer flag
		access(1'b1, a, d & keep(a), q, v);
	endtask

	// Read data and its valid flag from the one answer cycle
	task automatic read(input logic [7:0] a, output logic [7:0] d, output logic v);
		access(1'b0, a, 8'h00, d, v);
	endtask

	task automatic div_write(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_clock);
		o_synth_reset_ctrl <= 1'b1;
		repeat (3) @(negedge i_clock);
		write(a, d);
	endtask

	// Release, then allow the two sync stages and the copy
	task automatic div_release();
		@(negedge i_clock);
		o_synth_reset_ctrl <= 1'b0;
		repeat (4) @(negedge i_clock);
	endtask

	task automatic trig_set(input logic [2:0] m);
		write(8'h57, {5'h00, m});
		write(8'h57, {1'b1, 4'h0, m});
	endtask
endmodule // pco_host_model

`default_nettype wire

//--- pco_top_test.sv
// Self-checking bench for the configuration block.
// Assumes pco_pkg, pco_top and pco_host_model are compiled first.
`default_nettype none

module pco_top_test
	import pco_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic               clock;
	logic               resetn;
	logic               synth_en;
	logic               ui_tick;
	logic               reinit;
	logic               tstamp;
	logic               wr, rd, rst_ctrl, rvalid, ref_out, trig_en, pin;
	logic [7:0]         addr, wdata, rdata, d;
	logic               v;
	logic [6:0]         bias;
	logic [7:0][3:0]    pe;
	pco_div_cfg_t       div;
	logic [1:0]         ef, es;
	logic [5:0]         e3;
	int                 fail_count = 0;
	int                 num_checks = 0;
	int                 cycles = 0;
	int                 n;
	// Reset images, last entry unmapped
	logic [7:0]         ra [7] = '{8'h3c, 8'h3d, 8'h3e, 8'h3f, 8'h48, 8'h57, 8'h11};
	logic [7:0]         rv [7] = '{8'h01, 8'h00, 8'h20, 8'h4f, 8'h00, 8'h00, 8'h00};
	// Divider writes: address, data; reserved codes and ratio 0 included
	logic [15:0]        dv [6] = '{16'h3d09, 16'h3d06, 16'h3d0f, 16'h3e3f, 16'h3e00, 16'h3e01};

	pco_top i_dut (.i_clock(clock), .i_resetn(resetn), .i_reg_wr(wr), .i_reg_rd(rd),
		.i_reg_addr(addr), .i_reg_wdata(wdata), .i_synth_enable(synth_en),
		.i_synth_reset_ctrl(rst_ctrl), .i_ui_tick(ui_tick), .i_serdes_reinit(reinit),
		.i_timestamp_input(tstamp), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
		.o_ref_clock_out(ref_out), .o_div_cfg(div), .o_oscillator_bias(bias),
		.o_lane_preemphasis(pe), .o_trig_output_enable(trig_en), .o_trig_output_pin(pin));

	pco_host_model i_host (.i_clock(clock), .i_reg_rdata(rdata), .i_reg_rvalid(rvalid),
		.o_reg_wr(wr), .o_reg_rd(rd), .o_reg_addr(addr), .o_reg_wdata(wdata),
		.o_synth_reset_ctrl(rst_ctrl));

	// 40 MHz clock
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	// Wide enough for the longest concatenated compare
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic idle(input int k);
		repeat (k) @(negedge clock);
	endtask

	// Bounded wait for a trigger level; n returns the cycles spent
	task automatic wait_pin(input logic lv);
		n = 0;
		while (pin !== lv && n < 200) begin
			idle(1);
			n++;
		end
	endtask

	task automatic complete_run();
		$display("Checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// Whole run needs well under 2000 cycles; a hang is cut here
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			fail_count++;
			complete_run();
		end
	end

	initial begin
		resetn = 1'b0;
		synth_en = 1'b1;
		ui_tick = 1'b1;
		reinit = 1'b0;
		tstamp = 1'b0;
		idle(3);
		resetn = 1'b1;
		// Reset images, unmapped read answers zero
		foreach (ra[i]) begin
			i_host.read(ra[i], d, v);
			check({v, d}, {1'b1, rv[i]});
		end
		check(div, {2'h0, 2'h0, 6'h20});
		check({ref_out, bias, pe, trig_en, pin}, {1'b1, 7'h4f, 32'h0, 2'b00});
		$display("Test reset done");
		// Reference output follows bit and pin
		i_host.write(8'h3c, 8'h00);
		idle(2);
		check(ref_out, 1'b0);
		i_host.write(8'h3c, 8'h01);
		idle(2);
		check(ref_out, 1'b1);
		synth_en = 1'b0;
		idle(4);
		check(ref_out, 1'b0);
		synth_en = 1'b1;
		$display("Test reference output done");
		// Dividers hold during synth reset, reserved codes keep old value
		ef = 2'h0;
		es = 2'h0;
		e3 = 6'h20;
		foreach (dv[i]) begin
			i_host.div_write(dv[i][15:8], dv[i][7:0]);
			idle(3);
			check(div, {ef, es, e3});
			if (dv[i][15:8] == 8'h3e && dv[i][5:0] != 6'h00) e3 = dv[i][5:0];
			if (dv[i][15:8] == 8'h3d && dv[i][1:0] != 2'h3) ef = dv[i][1:0];
			if (dv[i][15:8] == 8'h3d && dv[i][3:2] != 2'h3) es = dv[i][3:2];
			i_host.div_release();
			check(div, {ef, es, e3});
		end
		$display("Test dividers done");
		i_host.write(8'h3f, 8'h4a);
		i_host.write(8'h48, 8'h0a);
		idle(2);
		check({bias, pe}, {7'h4a, {8{4'ha}}});
		$display("Test bias and lanes done");
		// Trigger clock half periods of 8, 16, 32 ticks
		for (int m = 0; m < 3; m++) begin
			i_host.trig_set(3'(m));
			check(trig_en, 1'b1);
			wait_pin(1'b1);
			wait_pin(1'b0);
			check(n, 8 << m);
		end
		wait_pin(1'b1);
		reinit = 1'b1;
		idle(3);
		check(pin, 1'b0);
		reinit = 1'b0;
		// Timestamp copy, then disable, then a reserved mode
		i_host.trig_set(3'h3);
		tstamp = 1'b1;
		idle(4);
		check(pin, 1'b1);
		i_host.write(8'h57, 8'h03);
		idle(2);
		check({trig_en, pin}, 2'b00);
		i_host.trig_set(3'h4);
		idle(4);
		check(pin, 1'b0);
		$display("Test trigger done");
		complete_run();
	end
endmodule // pco_top_test

`default_nettype wire
